// [ctrl_device.sv]
// Device end: control register bank with word-stream decode and one-shot readback select
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Host arms download before sending coefficients
// - Host sets tap count with arm
// - Armed: following words are coefficients plus checksum
// - Bit 14 selects overrange threshold next read
// - Bit 13 selects gain next read
// - Bit 12 selects offset next read
// - Bit 11 selects status next read
// - Host writes zero to bit 10
// - Host writes one to bit 3
// - Bit 9 starts filter synchronisation
// - Simultaneous sync aligns filters across devices
// - Bit 4 zero bypasses FIR stage
// - Decimation zero bypasses, 1 to 5 give two power value, 6 and 7 give zero
// - Bits 15 to 9 self clear
// - Bit 5 chooses halved or full clock
// - Bit 3 powers whole converter down
// - Bit 2 enables reduced-power mode
// - Each write is address then data word
// - Host sets at most one select bit
// - Bit 0 powers down input amplifier
// - Host writes one to second register bit 1
module ctrl_device (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// Link
	ctrl_link_if.device link,
	// Readback sources
	input wire logic [15:0] conv_word_i,
	input wire logic [15:0] ovr_thresh_i,
	input wire logic [15:0] gain_i,
	input wire logic [15:0] offset_i,
	input wire logic [15:0] status_i,
	// Filter control
	output logic fir_stage_use_o,
	output logic [2:0] decim_sel_o,
	output logic decim_bypass_o,
	output logic [5:0] decim_ratio_o,
	output logic [3:0] tap_count_sel_o,
	output logic sync_pulse_o,
	output logic coef_valid_o,
	output logic [15:0] coef_word_o,
	output logic coef_checksum_o,
	output logic coef_busy_o,
	// Clock and power control
	output logic internal_clock_en_o,
	output logic sleep_ctrl_o,
	output logic economy_mode_o,
	output logic amp_sleep_o,
	// Register readback
	output logic [15:0] filt_ctrl_o,
	output logic [15:0] clk_ctrl_o
);
	// ============================================================
	// Stream decode
	ctrl_pkg::wr_state_type state_reg;
	logic [15:0] addr_reg;
	logic [6:0] coef_left_reg;
	logic [15:0] filt_ctrl_reg;
	logic [15:0] clk_ctrl_reg;
	logic [2:0] rsel_reg;
	logic div_reg;
	logic [15:0] wdata;
	logic wr_filt;
	logic wr_clk;
	logic [6:0] coef_words;

	assign wdata = link.wr_word;
	assign wr_filt = link.wr_valid && state_reg == ctrl_pkg::ST_DATA && addr_reg == ctrl_pkg::FILT_CTRL_ADDR;
	assign wr_clk = link.wr_valid && state_reg == ctrl_pkg::ST_DATA && addr_reg == ctrl_pkg::CLK_CTRL_ADDR;
	// Two words per coefficient, coefficients are six times the odd-coded half of tap count
	assign coef_words = 7'((({3'h0, wdata[ctrl_pkg::TAP_HI:ctrl_pkg::TAP_LO]} + 7'h01) >> 1)
		* ctrl_pkg::TAPS_PER_STEP * 7'h02) + ctrl_pkg::CHECKSUM_WORDS;

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg <= ctrl_pkg::ST_ADDR;
			addr_reg <= 16'h0000;
			coef_left_reg <= 7'h00;
		end else if (link.wr_valid) begin
			unique case (state_reg)
				ctrl_pkg::ST_ADDR: begin
					addr_reg <= wdata;
					state_reg <= ctrl_pkg::ST_DATA;
				end
				ctrl_pkg::ST_DATA: begin
					if (wr_filt && wdata[ctrl_pkg::COEF_LOAD_ARM_BIT]
						&& wdata[ctrl_pkg::TAP_HI:ctrl_pkg::TAP_LO] != 4'h0) begin
						coef_left_reg <= coef_words;
						state_reg <= ctrl_pkg::ST_COEF;
					end else begin
						state_reg <= ctrl_pkg::ST_ADDR;
					end
				end
				ctrl_pkg::ST_COEF: begin
					coef_left_reg <= coef_left_reg - 7'h01;
					if (coef_left_reg == 7'h01) begin
						state_reg <= ctrl_pkg::ST_ADDR;
					end
				end
				default: state_reg <= ctrl_pkg::ST_ADDR;
			endcase
		end
	end

	// Coefficient word out
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			coef_valid_o <= 1'b0;
			coef_checksum_o <= 1'b0;
			coef_word_o <= 16'h0000;
		end else begin
			coef_valid_o <= link.wr_valid && state_reg == ctrl_pkg::ST_COEF;
			coef_checksum_o <= link.wr_valid && state_reg == ctrl_pkg::ST_COEF && coef_left_reg == 7'h01;
			if (link.wr_valid && state_reg == ctrl_pkg::ST_COEF) begin
				coef_word_o <= wdata;
			end
		end
	end
	assign coef_busy_o = state_reg == ctrl_pkg::ST_COEF;

	// ============================================================
	// Registers
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			filt_ctrl_reg <= ctrl_pkg::FILT_CTRL_RESET;
			clk_ctrl_reg <= ctrl_pkg::CLK_CTRL_RESET;
			sync_pulse_o <= 1'b0;
		end else begin
			sync_pulse_o <= wr_filt && wdata[ctrl_pkg::SYNC_BIT];
			if (wr_filt) begin
				filt_ctrl_reg <= (wdata & ~ctrl_pkg::SELF_CLEAR_MASK & ~ctrl_pkg::FILT_CTRL_CLEAR)
					| ctrl_pkg::FILT_CTRL_FORCE;
			end
			if (wr_clk) begin
				clk_ctrl_reg <= (wdata & ctrl_pkg::CLK_CTRL_WMASK) | ctrl_pkg::CLK_CTRL_FORCE;
			end
		end
	end

	// One-shot read select
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rsel_reg <= ctrl_pkg::RSEL_CONV;
		end else if (wr_filt) begin
			if (wdata[ctrl_pkg::RD_OVR_BIT]) begin
				rsel_reg <= ctrl_pkg::RSEL_OVR;
			end else if (wdata[ctrl_pkg::RD_GAIN_BIT]) begin
				rsel_reg <= ctrl_pkg::RSEL_GAIN;
			end else if (wdata[ctrl_pkg::RD_OFF_BIT]) begin
				rsel_reg <= ctrl_pkg::RSEL_OFF;
			end else if (wdata[ctrl_pkg::RD_STAT_BIT]) begin
				rsel_reg <= ctrl_pkg::RSEL_STAT;
			end else begin
				rsel_reg <= ctrl_pkg::RSEL_CONV;
			end
		end else if (link.rd_strobe) begin
			rsel_reg <= ctrl_pkg::RSEL_CONV;
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			link.rd_word <= 16'h0000;
			link.rd_valid <= 1'b0;
		end else begin
			link.rd_valid <= link.rd_strobe;
			if (link.rd_strobe) begin
				case (rsel_reg)
					ctrl_pkg::RSEL_OVR: link.rd_word <= ovr_thresh_i;
					ctrl_pkg::RSEL_GAIN: link.rd_word <= gain_i;
					ctrl_pkg::RSEL_OFF: link.rd_word <= offset_i;
					ctrl_pkg::RSEL_STAT: link.rd_word <= status_i;
					default: link.rd_word <= conv_word_i;
				endcase
			end
		end
	end

	// ============================================================
	// Internal clock enable
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			div_reg <= 1'b0;
		end else begin
			div_reg <= ~div_reg;
		end
	end
	assign internal_clock_en_o = clk_ctrl_reg[ctrl_pkg::CLK_HALVE_N_BIT] | div_reg;

	// Decoded controls
	assign fir_stage_use_o = filt_ctrl_reg[ctrl_pkg::FIR_USE_BIT];
	assign decim_sel_o = filt_ctrl_reg[ctrl_pkg::DECIM_HI:ctrl_pkg::DECIM_LO];
	assign decim_bypass_o = decim_sel_o == 3'h0;
	assign decim_ratio_o = (decim_sel_o > ctrl_pkg::DECIM_MAX) ? 6'h00 : 6'(6'h01 << decim_sel_o);
	assign tap_count_sel_o = filt_ctrl_reg[ctrl_pkg::TAP_HI:ctrl_pkg::TAP_LO];
	assign sleep_ctrl_o = clk_ctrl_reg[ctrl_pkg::SLEEP_BIT];
	assign economy_mode_o = clk_ctrl_reg[ctrl_pkg::ECONOMY_BIT];
	assign amp_sleep_o = clk_ctrl_reg[ctrl_pkg::AMP_SLEEP_BIT];
	assign filt_ctrl_o = filt_ctrl_reg;
	assign clk_ctrl_o = clk_ctrl_reg;
endmodule // ctrl_device
`default_nettype wire

// [ctrl_host.sv]
// Host end: sends address then data words and issues read strobes
`timescale 1ns/10ps
`default_nettype none
module ctrl_host (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// Link
	ctrl_link_if.host link,
	// Register write request
	input wire logic req_valid_i,
	input wire logic [15:0] req_addr_i,
	input wire logic [15:0] req_data_i,
	output logic req_ready_o,
	// Raw stream word (coefficients, checksum)
	input wire logic raw_valid_i,
	input wire logic [15:0] raw_word_i,
	// Read request
	input wire logic read_i,
	output logic [15:0] read_data_o,
	output logic read_done_o
);
	ctrl_pkg::host_state_type state_reg;
	logic [15:0] addr_reg;
	logic [15:0] data_reg;
	logic [15:0] fixed_data;

	// Force mandated bits by target register
	always_comb begin
		fixed_data = req_data_i;
		if (req_addr_i == ctrl_pkg::FILT_CTRL_ADDR) begin
			fixed_data = (req_data_i & ~ctrl_pkg::FILT_CTRL_CLEAR) | ctrl_pkg::FILT_CTRL_FORCE;
			if (req_data_i[ctrl_pkg::RD_OVR_BIT]) begin
				fixed_data[ctrl_pkg::RD_OFF_BIT:ctrl_pkg::RD_STAT_BIT] = 2'h0;
				fixed_data[ctrl_pkg::RD_GAIN_BIT] = 1'b0;
			end else if (req_data_i[ctrl_pkg::RD_GAIN_BIT]) begin
				fixed_data[ctrl_pkg::RD_OFF_BIT] = 1'b0;
				fixed_data[ctrl_pkg::RD_STAT_BIT] = 1'b0;
			end else if (req_data_i[ctrl_pkg::RD_OFF_BIT]) begin
				fixed_data[ctrl_pkg::RD_STAT_BIT] = 1'b0;
			end
		end else if (req_addr_i == ctrl_pkg::CLK_CTRL_ADDR) begin
			fixed_data = (req_data_i & ctrl_pkg::CLK_CTRL_WMASK) | ctrl_pkg::CLK_CTRL_FORCE;
		end
	end

	assign req_ready_o = state_reg == ctrl_pkg::H_IDLE;

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg <= ctrl_pkg::H_IDLE;
			addr_reg <= 16'h0000;
			data_reg <= 16'h0000;
			link.wr_valid <= 1'b0;
			link.wr_word <= 16'h0000;
		end else begin
			link.wr_valid <= 1'b0;
			unique case (state_reg)
				ctrl_pkg::H_IDLE: begin
					if (req_valid_i) begin
						addr_reg <= req_addr_i;
						data_reg <= fixed_data;
						state_reg <= ctrl_pkg::H_ADDR;
					end else if (raw_valid_i) begin
						link.wr_valid <= 1'b1;
						link.wr_word <= raw_word_i;
					end
				end
				ctrl_pkg::H_ADDR: begin
					link.wr_valid <= 1'b1;
					link.wr_word <= addr_reg;
					state_reg <= ctrl_pkg::H_DATA;
				end
				ctrl_pkg::H_DATA: begin
					link.wr_valid <= 1'b1;
					link.wr_word <= data_reg;
					state_reg <= ctrl_pkg::H_IDLE;
				end
				default: state_reg <= ctrl_pkg::H_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			link.rd_strobe <= 1'b0;
			read_data_o <= 16'h0000;
			read_done_o <= 1'b0;
		end else begin
			link.rd_strobe <= read_i && state_reg == ctrl_pkg::H_IDLE && !req_valid_i;
			read_done_o <= link.rd_valid;
			if (link.rd_valid) begin
				read_data_o <= link.rd_word;
			end
		end
	end
endmodule // ctrl_host
`default_nettype wire

// [ctrl_link_asserts.sv]
// Link protocol checker for the control register bank
`timescale 1ns/10ps
`default_nettype none
module ctrl_link_asserts (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// Link
	input wire logic wr_valid,
	input wire logic [15:0] wr_word,
	input wire logic rd_strobe,
	input wire logic rd_valid
);
	// ============================================================
	// Stream phase tracking
	logic data_next_reg;
	logic [15:0] last_addr_reg;
	logic [6:0] coef_left_reg;
	logic addr_word;
	logic [6:0] coef_total;

	// Words after an armed write: two per coefficient plus checksum
	assign coef_total = ((7'(wr_word[8:5]) + 7'h01) >> 1) * 7'h0C + 7'h01;
	assign addr_word = wr_valid && coef_left_reg == 7'h00 && !data_next_reg;

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			data_next_reg <= 1'b0;
			last_addr_reg <= 16'h0000;
			coef_left_reg <= 7'h00;
		end else if (wr_valid) begin
			if (coef_left_reg != 7'h00) begin
				coef_left_reg <= coef_left_reg - 7'h01;
			end else if (data_next_reg) begin
				data_next_reg <= 1'b0;
				if (last_addr_reg == 16'h0001 && wr_word[15] && wr_word[8:5] != 4'h0) begin
					coef_left_reg <= coef_total;
				end
			end else begin
				data_next_reg <= 1'b1;
				last_addr_reg <= wr_word;
			end
		end
	end

	// ============================================================
	// Assertions
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	read_answer_a: assert property (rd_strobe |=> rd_valid)
		else $error("read strobe not answered");
	read_cause_a: assert property (rd_valid |-> $past(rd_strobe))
		else $error("read answer without strobe");
	read_pulse_a: assert property (rd_valid |=> !rd_valid)
		else $error("read answer longer than one cycle");
	addr_pair_a: assert property (addr_word |=> wr_valid)
		else $error("address word not followed by data word");
	filt_fixed_a: assert property (addr_word && wr_word == 16'h0001 |=> !wr_word[10] && wr_word[3])
		else $error("fixed bits wrong in filter data word");
	one_sel_a: assert property (addr_word && wr_word == 16'h0001 |=> $onehot0(wr_word[14:11]))
		else $error("several read selects in one word");
	clk_fixed_a: assert property (addr_word && wr_word == 16'h0002 |=> wr_word[1] && (wr_word & 16'hFFD0) == 16'h0000)
		else $error("fixed bits wrong in clock data word");
	arm_taps_a: assert property (addr_word && wr_word == 16'h0001 ##1 wr_word[15] |-> wr_word[8:5] != 4'h0)
		else $error("download armed without tap count");
endmodule // ctrl_link_asserts
`default_nettype wire

// [ctrl_link_if.sv]
// Interface carrying the 16-bit word stream and read strobe between host and device
`timescale 1ns/10ps
`default_nettype none
interface ctrl_link_if;
	logic wr_valid;
	logic [15:0] wr_word;
	logic rd_strobe;
	logic [15:0] rd_word;
	logic rd_valid;
	modport device (input wr_valid, input wr_word, input rd_strobe, output rd_word, output rd_valid);
	modport host (output wr_valid, output wr_word, output rd_strobe, input rd_word, input rd_valid);
endinterface
`default_nettype wire

// [ctrl_pkg.sv]
// Package with register map, field positions and shared types for the control register bank
`default_nettype none
package ctrl_pkg;
	// ============================================================
	// Register addresses and reset values
	localparam logic [15:0] FILT_CTRL_ADDR = 16'h0001;
	localparam logic [15:0] CLK_CTRL_ADDR = 16'h0002;
	localparam logic [15:0] FILT_CTRL_RESET = 16'h001A;
	localparam logic [15:0] CLK_CTRL_RESET = 16'h009B;
	// ============================================================
	// Filter and readback control fields
	localparam int COEF_LOAD_ARM_BIT = 15;
	localparam int RD_OVR_BIT = 14;
	localparam int RD_GAIN_BIT = 13;
	localparam int RD_OFF_BIT = 12;
	localparam int RD_STAT_BIT = 11;
	localparam int ZERO_BIT = 10;
	localparam int SYNC_BIT = 9;
	localparam int TAP_HI = 8;
	localparam int TAP_LO = 5;
	localparam int FIR_USE_BIT = 4;
	localparam int ONE_BIT = 3;
	localparam int DECIM_HI = 2;
	localparam int DECIM_LO = 0;
	localparam logic [15:0] SELF_CLEAR_MASK = 16'hFE00;
	localparam logic [2:0] DECIM_MAX = 3'h5;
	// ============================================================
	// Clock and power control fields
	localparam int CLK_HALVE_N_BIT = 5;
	localparam int SLEEP_BIT = 3;
	localparam int ECONOMY_BIT = 2;
	localparam int CLK_ONE_BIT = 1;
	localparam int AMP_SLEEP_BIT = 0;
	localparam logic [15:0] CLK_CTRL_WMASK = 16'h002F;
	localparam logic [15:0] CLK_CTRL_FORCE = 16'h0002;
	localparam logic [15:0] FILT_CTRL_FORCE = 16'h0008;
	localparam logic [15:0] FILT_CTRL_CLEAR = 16'h0400;
	// ============================================================
	// Coefficient download: two words per coefficient plus checksum
	localparam logic [6:0] TAPS_PER_STEP = 7'h06;
	localparam logic [6:0] CHECKSUM_WORDS = 7'h01;
	// ============================================================
	// Read source selection
	typedef enum logic [2:0] {
		RSEL_CONV = 3'h0,
		RSEL_OVR = 3'h1,
		RSEL_GAIN = 3'h3,
		RSEL_OFF = 3'h2,
		RSEL_STAT = 3'h6
	} read_sel_type;
	// Device write-stream state
	typedef enum logic [1:0] {
		ST_ADDR = 2'h0,
		ST_DATA = 2'h1,
		ST_COEF = 2'h3
	} wr_state_type;
	// Host sequencing state
	typedef enum logic [1:0] {
		H_IDLE = 2'h0,
		H_ADDR = 2'h1,
		H_DATA = 2'h3
	} host_state_type;
endpackage
`default_nettype wire

// [tb.sv]
// Self-checking bench joining host and device ends of the control link
`timescale 1ns/10ps
`default_nettype none
module tb;
	// ============================================================
	// Signals
	logic mclk_i = 1'b0, rstn_i = 1'b0, req_valid_i = 1'b0, raw_valid_i = 1'b0, read_i = 1'b0;
	logic [15:0] req_addr_i = 16'h0000, req_data_i = 16'h0000, raw_word_i = 16'h0000, last_coef;
	logic [15:0] src [5] = '{16'h1234, 16'hCCCC, 16'hA000, 16'h0055, 16'h0F0F};
	logic req_ready_o, read_done_o, fir_stage_use_o, decim_bypass_o, sync_pulse_o, coef_valid_o;
	logic coef_checksum_o, coef_busy_o, internal_clock_en_o, sleep_ctrl_o, economy_mode_o, amp_sleep_o;
	logic [15:0] read_data_o, coef_word_o, filt_ctrl_o, clk_ctrl_o;
	logic [2:0] decim_sel_o;
	logic [5:0] decim_ratio_o;
	logic [3:0] tap_count_sel_o;
	int err_total = 0, tests_run = 0, sync_n = 0, coef_n = 0, sum_n = 0, ick_n = 0;
	// ============================================================
	// Instances
	ctrl_link_if link ();
	ctrl_device u_ctrl_device (.mclk_i(mclk_i), .rstn_i(rstn_i), .link(link), .conv_word_i(src[0]),
		.ovr_thresh_i(src[1]), .gain_i(src[2]), .offset_i(src[3]), .status_i(src[4]),
		.fir_stage_use_o(fir_stage_use_o), .decim_sel_o(decim_sel_o), .decim_bypass_o(decim_bypass_o),
		.decim_ratio_o(decim_ratio_o), .tap_count_sel_o(tap_count_sel_o), .sync_pulse_o(sync_pulse_o),
		.coef_valid_o(coef_valid_o), .coef_word_o(coef_word_o), .coef_checksum_o(coef_checksum_o),
		.coef_busy_o(coef_busy_o), .internal_clock_en_o(internal_clock_en_o), .sleep_ctrl_o(sleep_ctrl_o),
		.economy_mode_o(economy_mode_o), .amp_sleep_o(amp_sleep_o), .filt_ctrl_o(filt_ctrl_o),
		.clk_ctrl_o(clk_ctrl_o));
	ctrl_host u_ctrl_host (.mclk_i(mclk_i), .rstn_i(rstn_i), .link(link), .req_valid_i(req_valid_i),
		.req_addr_i(req_addr_i), .req_data_i(req_data_i), .req_ready_o(req_ready_o),
		.raw_valid_i(raw_valid_i), .raw_word_i(raw_word_i), .read_i(read_i),
		.read_data_o(read_data_o), .read_done_o(read_done_o));
	ctrl_link_asserts u_ctrl_link_asserts (.mclk_i(mclk_i), .rstn_i(rstn_i), .wr_valid(link.wr_valid),
		.wr_word(link.wr_word), .rd_strobe(link.rd_strobe), .rd_valid(link.rd_valid));
	// ============================================================
	// Clock and pulse counters
	always #25 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		if (sync_pulse_o === 1'b1) sync_n <= sync_n + 1;
		if (internal_clock_en_o === 1'b1) ick_n <= ick_n + 1;
		if (coef_checksum_o === 1'b1) sum_n <= sum_n + 1;
		if (coef_valid_o === 1'b1) begin
			coef_n <= coef_n + 1;
			last_coef <= coef_word_o;
		end
	end
	// ============================================================
	// Shared tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		int n = 0;
		req_addr_i <= a;
		req_data_i <= d;
		req_valid_i <= 1'b1;
		do begin @(posedge mclk_i); n++; end while (req_ready_o !== 1'b1 && n < 20);
		req_valid_i <= 1'b0;
		repeat (6) @(posedge mclk_i);
	endtask
	task automatic rd(output logic [15:0] v);
		int n = 0;
		read_i <= 1'b1;
		@(posedge mclk_i);
		read_i <= 1'b0;
		do begin @(posedge mclk_i); n++; end while (read_done_o !== 1'b1 && n < 20);
		v = read_data_o;
		@(posedge mclk_i);
	endtask
	// ============================================================
	// Scenarios
	task automatic t_reset;
		check(filt_ctrl_o, 16'h001A);
		check(clk_ctrl_o, 16'h009B);
		check({10'h0, decim_ratio_o}, 16'h0004);
		check({15'h0, fir_stage_use_o}, 16'h0001);
		check({15'h0, req_ready_o}, 16'h0001);
	endtask
	task automatic t_filt;
		for (int d = 0; d < 8; d++) begin
			logic [15:0] v;
			v = 16'h0008 | 16'(d) | (16'(d) << 5) | (d[0] ? 16'h0010 : 16'h0000);
			wr(16'h0001, v | 16'h0200);
			check(filt_ctrl_o, v);
			check({15'h0, decim_bypass_o}, {15'h0, d == 0});
			check({10'h0, decim_ratio_o}, d > 5 ? 16'h0000 : 16'h0001 << d);
			check({13'h0, decim_sel_o}, 16'(d));
			check({15'h0, fir_stage_use_o}, {15'h0, d[0]});
			check({12'h0, tap_count_sel_o}, 16'(d));
			check(16'(sync_n), 16'(d + 1));
		end
	endtask
	task automatic t_clk;
		logic [15:0] vals [4] = '{16'hFFE0, 16'h0008, 16'h0004, 16'h0001};
		int n0;
		for (int i = 0; i < 4; i++) begin
			wr(16'h0002, vals[i]);
			check(clk_ctrl_o, (vals[i] & 16'h002D) | 16'h0002);
			check({12'h0, sleep_ctrl_o, economy_mode_o, 1'b0, amp_sleep_o}, vals[i] & 16'h000D);
			n0 = ick_n;
			repeat (8) @(posedge mclk_i);
			check(16'(ick_n - n0), vals[i][5] ? 16'h0008 : 16'h0004);
		end
	endtask
	task automatic t_read;
		logic [15:0] v;
		rd(v);
		check(v, src[0]);
		for (int k = 0; k < 4; k++) begin
			wr(16'h0001, (16'h4000 >> k) | 16'h0008);
			check(filt_ctrl_o & 16'hFE00, 16'h0000);
			rd(v);
			check(v, src[k + 1]);
			rd(v);
			check(v, src[0]);
		end
		wr(16'h0001, 16'h7C00);
		check(filt_ctrl_o, 16'h0008);
		rd(v);
		check(v, src[1]);
		wr(16'h0001, 16'h3808);
		rd(v);
		check(v, src[2]);
	endtask
	task automatic t_coef;
		int c0, s0;
		c0 = coef_n;
		s0 = sum_n;
		wr(16'h0001, 16'h8039);
		check({12'h0, tap_count_sel_o}, 16'h0001);
		check({15'h0, coef_busy_o}, 16'h0001);
		for (int i = 0; i < 13; i++) begin
			raw_word_i <= (i == 12) ? 16'h0E6B : 16'h1000 + 16'(i);
			raw_valid_i <= 1'b1;
			@(posedge mclk_i);
		end
		raw_valid_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
		check(16'(coef_n - c0), 16'h000D);
		check(16'(sum_n - s0), 16'h0001);
		check(last_coef, 16'h0E6B);
		check({15'h0, coef_busy_o}, 16'h0000);
		check(filt_ctrl_o, 16'h0039);
		wr(16'h0001, 16'h000A);
		check(filt_ctrl_o, 16'h000A);
	endtask
	// ============================================================
	// Main sequence and watchdog
	initial begin
		repeat (2) @(posedge mclk_i);
		rstn_i <= 1'b1;
		@(posedge mclk_i);
		t_reset;
		t_filt;
		t_clk;
		t_read;
		t_coef;
		stop_test;
	end
	initial begin
		repeat (5000) @(posedge mclk_i);
		err_total++;
		stop_test;
	end
endmodule // tb
`default_nettype wire
